// >>> design/gms_top.sv
// Start-up mode selector, serial format decoder and LED encoder with an AHB-Lite slave.
// Assumes switches, network status and request strobes are synchronous to hclk.
//
// What this block does
// - Both switches F config, E test, D reserved; else data exchange.
// - Config mode: 9600 baud, no parity, one stop bit, serial LED blinks red.
// - Config and test modes only allowed with single-ended RS232 line.
// - Data exchange characters always one start, eight data, one stop bit.
// - Baud switch 0 to 6 picks 2400 up to 115000; 7 to F reserved.
// - Line switch 0-8 picks type and even, none, odd parity; 9 to E reserved.
// - Line switch F gives RS232 even; RTU unit always 1, TCP unit ignored.
// - Ethernet LED: green active, flashing waiting, green/red init, red error.
// - System LED flashes red in config or test, steady red on error.
// - Four error LEDs show error number 0 to 15 in binary.
// - Link/activity, full duplex and 100 Mbit indicators follow the port.
// - Ethernet port runs 10 or 100 Mbit with automatic crossover.
// - Errors 1-5 held until reset; warnings 6-15 cleared after one minute.
// - Normally a 4-bit request counter wraps 15 to 0 and shows on LEDs.
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`include "gms_cfg.svh"

module gms_top
   import gms_pkg::*;
#(
   parameter int WARN_CYC = `GMS_WARN_CYC,
   parameter int BLINK_CYC = `GMS_BLINK_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [3:0] baud_select_switch,
   input wire logic [3:0] line_parity_select_switch,
   input wire logic [7:0] rtu_unit_identifier,
   input wire logic eth_link_pulse,
   input wire logic eth_traffic,
   input wire logic eth_full_duplex,
   input wire logic eth_speed_100,
   input wire logic eth_mdi_crossed,
   input wire logic req_done,
   input wire logic [3:0] err_code,
   input wire logic err_strobe,
   output gms_link_t link_cfg,
   output logic [7:0] rtu_unit_out,
   output logic eth_mdix_sel,
   output gms_led_t leds,
   output logic irq
);

   typedef struct packed {
      logic sampled;
      logic [1:0] mode;
      logic [3:0] baud_sw;
      logic [3:0] line_sw;
      gms_link_t link;
      logic [7:0] unit;
      logic mdix;
      logic [1:0] eth_state;   // 0 active, 1 waiting, 2 init, 3 error
      logic app_err;
      logic [3:0] err_num;
      logic err_sev;
      logic [31:0] warn_cnt;
      logic [3:0] req_cnt;
      logic [31:0] blink_cnt;
      logic blink;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic bus_st;
      logic bus_wr;
      logic [7:0] bus_addr;
      logic [31:0] rdata;
      gms_led_t led;
      logic irq;
      logic rdy;               // Registered copy of hreadyout
      logic resp;              // Registered copy of hresp
   } gms_state_t;

   gms_state_t st_r;
   gms_state_t st_nxt;

   // Baud table, used by the decode for data exchange
   function automatic logic [16:0] gms_baud(input logic [3:0] sel);
      case (sel)
         4'h0: gms_baud = 17'd2400;
         4'h1: gms_baud = 17'd4800;
         4'h2: gms_baud = 17'd9600;
         4'h3: gms_baud = 17'd19200;
         4'h4: gms_baud = 17'd38400;
         4'h5: gms_baud = 17'd57600;
         4'h6: gms_baud = 17'd115000;
         default: gms_baud = 17'd0;
      endcase
   endfunction

   // Mode from the two switches; used for decode and the mode register
   function automatic logic [1:0] gms_mode(input logic [3:0] a, input logic [3:0] b);
      if (a == `GMS_SW_CFG && b == `GMS_SW_CFG) begin
         gms_mode = 2'h1;
      end else if (a == `GMS_SW_TEST && b == `GMS_SW_TEST) begin
         gms_mode = 2'h2;
      end else if (a == `GMS_SW_RSVD && b == `GMS_SW_RSVD) begin
         gms_mode = 2'h3;
      end else begin
         gms_mode = 2'h0;
      end
   endfunction

   logic addr_phase;
   assign addr_phase = hsel && hready && htrans[1];

   // Next-state logic for the whole block
   always_comb begin
      logic [1:0] m;
      logic [3:0] ls;
      logic [3:0] errv;
      logic [2:0] ev;
      m = 2'h0;
      ls = 4'h0;
      errv = 4'h0;
      ev = 3'h0;
      st_nxt = st_r;

      if (!st_r.sampled) begin
         m = gms_mode(baud_select_switch, line_parity_select_switch);
         ls = line_parity_select_switch;
         st_nxt.sampled = 1'b1;
         st_nxt.baud_sw = baud_select_switch;
         st_nxt.line_sw = line_parity_select_switch;
         st_nxt.mode = m;
         st_nxt.link.data_bits = `GMS_DATA_BITS;
         st_nxt.link.stop_bits = `GMS_STOP_BITS;
         if (m == 2'h1 || m == 2'h2) begin
            st_nxt.link.baud = `GMS_CFG_BAUD;
            st_nxt.link.parity = 2'h1;
            st_nxt.link.line = GMS_L_RS232;
            st_nxt.link.valid = 1'b1;
         end else if (m == 2'h0) begin
            st_nxt.link.stop_bits = `GMS_STOP_BITS;
            st_nxt.link.baud = gms_baud(baud_select_switch);
            if (ls <= `GMS_LINE_LAST) begin
               st_nxt.link.line = 2'(ls % 4'h3);
               st_nxt.link.parity = 2'(ls / 4'h3);
               st_nxt.link.valid = (baud_select_switch <= `GMS_BAUD_LAST);
            end else if (ls == `GMS_SW_FIXED) begin
               st_nxt.link.line = GMS_L_RS232;
               st_nxt.link.parity = 2'h0;
               st_nxt.link.valid = (baud_select_switch <= `GMS_BAUD_LAST);
            end else begin
               st_nxt.link.valid = 1'b0;
            end
         end else begin
            st_nxt.link.valid = 1'b0;
         end
      end

      // unit id forced to 1 in fixed setting
      st_nxt.unit = (st_r.line_sw == `GMS_SW_FIXED) ? `GMS_RTU_UNIT : rtu_unit_identifier;
      // auto crossover follows the detected pairing
      st_nxt.mdix = eth_mdi_crossed;

      // Blink base
      if (st_r.blink_cnt >= 32'(BLINK_CYC - 1)) begin
         st_nxt.blink_cnt = 32'h0;
         st_nxt.blink = ~st_r.blink;
      end else begin
         st_nxt.blink_cnt = st_r.blink_cnt + 32'h1;
      end

      if (req_done) begin
         st_nxt.req_cnt = st_r.req_cnt + 4'h1;
         if (st_r.req_cnt == 4'hF) begin
            ev[`GMS_IRQ_WRAP] = 1'b1;
         end
      end

      // severe errors stick, warnings time out
      if (st_r.err_num != 4'h0 && !st_r.err_sev) begin
         if (st_r.warn_cnt >= 32'(WARN_CYC - 1)) begin
            st_nxt.err_num = 4'h0;
            st_nxt.warn_cnt = 32'h0;
         end else begin
            st_nxt.warn_cnt = st_r.warn_cnt + 32'h1;
         end
      end
      if (err_strobe && err_code != 4'h0 && !st_r.err_sev) begin
         st_nxt.err_num = err_code;
         st_nxt.warn_cnt = 32'h0;
         st_nxt.err_sev = (err_code <= `GMS_SEVERE_LAST);
         if (err_code <= `GMS_SEVERE_LAST) begin
            ev[`GMS_IRQ_SEVERE] = 1'b1;
         end else begin
            ev[`GMS_IRQ_WARN] = 1'b1;
         end
      end

      // Bus: write in the data phase, read in the address phase; read clears status but new events win
      // Zero wait states and OKAY only, still taken from flops like every output
      st_nxt.rdy = 1'b1;
      st_nxt.resp = 1'b0;
      st_nxt.bus_st = 1'b0;
      if (st_r.bus_st) begin
         if (st_r.bus_wr) begin
            case (st_r.bus_addr)
               `GMS_OFF_ETH: st_nxt.eth_state = hwdata[1:0];
               `GMS_OFF_ERR: st_nxt.app_err = hwdata[0];
               `GMS_OFF_IRQ_MASK: st_nxt.irq_mask = hwdata[2:0];
               default: ;
            endcase
         end
      end
      if (addr_phase) begin
         st_nxt.bus_st = 1'b1;
         st_nxt.bus_wr = hwrite;
         st_nxt.bus_addr = haddr;
         st_nxt.rdata = 32'h0;
         if (!hwrite) begin
            case (haddr)
               `GMS_OFF_MODE: st_nxt.rdata = {24'h0, st_r.line_sw, st_r.baud_sw} |
                                             {22'h0, st_r.mode, 8'h0};
               `GMS_OFF_LINK: st_nxt.rdata = {4'h0, st_r.link};
               `GMS_OFF_ETH: st_nxt.rdata = {30'h0, st_r.eth_state};
               `GMS_OFF_ERR: st_nxt.rdata = {26'h0, st_r.err_sev, st_r.app_err, st_r.err_num};
               `GMS_OFF_IRQ_STAT: begin
                  st_nxt.rdata = {29'h0, st_r.irq_stat};
                  st_nxt.irq_stat = 3'h0;
               end
               `GMS_OFF_IRQ_MASK: st_nxt.rdata = {29'h0, st_r.irq_mask};
               `GMS_OFF_REQ: st_nxt.rdata = {28'h0, st_r.req_cnt};
               default: st_nxt.rdata = 32'h0;
            endcase
         end
      end

      // Events are merged after the read-clear, so an event in the read cycle is kept
      st_nxt.irq_stat = st_nxt.irq_stat | ev;

      case (st_r.eth_state)
         2'h0: begin
            st_nxt.led.eth_green = 1'b1;
            st_nxt.led.eth_red = 1'b0;
         end
         2'h1: begin
            st_nxt.led.eth_green = st_r.blink;
            st_nxt.led.eth_red = 1'b0;
         end
         2'h2: begin
            st_nxt.led.eth_green = st_r.blink;
            st_nxt.led.eth_red = ~st_r.blink;
         end
         default: begin
            st_nxt.led.eth_green = 1'b0;
            st_nxt.led.eth_red = 1'b1;
         end
      endcase

      // system LED, error overrides mode blink
      st_nxt.led.sys_green = 1'b0;
      if (st_r.err_num != 4'h0 || st_r.app_err) begin
         st_nxt.led.sys_red = 1'b1;
      end else begin
         st_nxt.led.sys_red = (st_r.mode == 2'h1 || st_r.mode == 2'h2) & st_r.blink;
      end
      // serial LED blinks red in config
      st_nxt.led.rs_red = (st_r.mode == 2'h1) & st_r.blink;

      // error number, else counter; app error blanks them
      errv = (st_r.err_num != 4'h0) ? st_r.err_num : st_r.req_cnt;
      st_nxt.led.err = st_r.app_err ? 4'h0 : errv;

      st_nxt.led.link_act = eth_link_pulse | eth_traffic;
      st_nxt.led.full_dup = eth_full_duplex;
      st_nxt.led.fast = eth_speed_100;

      st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link_cfg = st_r.link;
   assign rtu_unit_out = st_r.unit;
   assign eth_mdix_sel = st_r.mdix;
   assign leds = st_r.led;
   assign irq = st_r.irq;
   assign hrdata = st_r.rdata;
   assign hreadyout = st_r.rdy;
   assign hresp = st_r.resp;

   // Checks
   a_mode_cfg_decode: assert property (@(posedge hclk) disable iff (!hresetn)
      !st_r.sampled && baud_select_switch == 4'hF && line_parity_select_switch == 4'hF
      |=> st_r.mode == 2'h1) else $error("config mode not decoded");
   a_cfg_fixed_link: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.sampled && st_r.mode == 2'h1 |-> link_cfg.baud == 17'd9600 && link_cfg.parity == 2'h1)
      else $error("config link not fixed");
   a_cfg_line_rs232: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.sampled && st_r.mode != 2'h0 && link_cfg.valid |-> link_cfg.line == 2'h0)
      else $error("config/test not on RS232");
   a_frame_eight_one: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.sampled |-> link_cfg.data_bits == 4'h8 && link_cfg.stop_bits == 2'h1)
      else $error("frame format wrong");
   a_baud_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.sampled && st_r.mode == 2'h0 && st_r.baud_sw > 4'h6 |-> !link_cfg.valid)
      else $error("reserved baud accepted");
   a_fixed_unit_one: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.line_sw == 4'hF |=> rtu_unit_out == 8'h01) else $error("unit not forced");
   a_eth_error_red: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.eth_state == 2'h3 |=> leds.eth_red && !leds.eth_green) else $error("eth red missing");
   a_sys_error_red: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.err_num != 4'h0 |=> leds.sys_red) else $error("system red missing");
   a_severe_held: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.err_sev |=> st_r.err_sev && $stable(st_r.err_num)) else $error("severe error lost");
   a_switch_held: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.sampled |=> $stable(st_r.baud_sw) && $stable(st_r.mode)) else $error("switch moved");
   a_req_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
      req_done && st_r.req_cnt == 4'hF |=> st_r.req_cnt == 4'h0) else $error("counter no wrap");
   a_wrap_sets_stat: assert property (@(posedge hclk) disable iff (!hresetn)
      req_done && st_r.req_cnt == 4'hF |=> st_r.irq_stat[`GMS_IRQ_WRAP])
      else $error("wrap status lost");

   c_cfg_mode: cover property (@(posedge hclk) st_r.mode == 2'h1);
   c_warn_timeout: cover property (@(posedge hclk) st_r.err_num != 4'h0 ##1 st_r.err_num == 4'h0);
   c_irq_raised: cover property (@(posedge hclk) irq);
endmodule

// >>> pkg/gms_cfg.svh
// Offsets, field positions, switch codes and timing counts of the mode selector.
// Assumes a 20 MHz hclk; included by the design file and the testbench.
`ifndef GMS_CFG_SVH
`define GMS_CFG_SVH

// Register byte offsets
`define GMS_OFF_MODE 8'h00
`define GMS_OFF_LINK 8'h04
`define GMS_OFF_ETH 8'h08
`define GMS_OFF_ERR 8'h0C
`define GMS_OFF_IRQ_STAT 8'h10
`define GMS_OFF_IRQ_MASK 8'h14
`define GMS_OFF_REQ 8'h18

// Switch codes
`define GMS_SW_CFG 4'hF
`define GMS_SW_TEST 4'hE
`define GMS_SW_RSVD 4'hD
`define GMS_SW_FIXED 4'hF
`define GMS_BAUD_LAST 4'h6
`define GMS_LINE_LAST 4'h8
`define GMS_SEVERE_LAST 4'h5
`define GMS_RTU_UNIT 8'h01
`define GMS_CFG_BAUD 17'd9600

// Character format: data bits and stop bits
`define GMS_DATA_BITS 4'h8
`define GMS_STOP_BITS 2'h1

// Timing
`define GMS_CLK_HZ 20000000
`define GMS_WARN_S 60
`define GMS_WARN_CYC (`GMS_WARN_S * `GMS_CLK_HZ)
`define GMS_BLINK_MS 250
`define GMS_BLINK_CYC ((`GMS_BLINK_MS * `GMS_CLK_HZ) / 1000)

// Interrupt status bits
`define GMS_IRQ_SEVERE 0
`define GMS_IRQ_WARN 1
`define GMS_IRQ_WRAP 2

`endif

// >>> pkg/gms_pkg.sv
// Types shared by the mode selector design.
// Assumes gms_cfg.svh holds the numeric constants.
package gms_pkg;
   typedef enum {GMS_M_DATA, GMS_M_CFG, GMS_M_TEST, GMS_M_RSVD} gms_mode_t;
   typedef enum {GMS_P_EVEN, GMS_P_NONE, GMS_P_ODD} gms_par_t;
   typedef enum logic [1:0] {GMS_L_RS232, GMS_L_RS422, GMS_L_RS485} gms_line_t;
   typedef enum {GMS_B_IDLE, GMS_B_DATA} gms_bus_t;

   // Serial link setting driven to the UART core
   typedef struct packed {
      logic [16:0] baud;
      logic [1:0] line;
      logic [1:0] parity;      // 0 even, 1 none, 2 odd
      logic [3:0] data_bits;
      logic [1:0] stop_bits;
      logic valid;             // Setting is not reserved
   } gms_link_t;

   // LED bundle
   typedef struct packed {
      logic eth_green;
      logic eth_red;
      logic sys_green;
      logic sys_red;
      logic rs_red;
      logic [3:0] err;
      logic link_act;
      logic full_dup;
      logic fast;
   } gms_led_t;
endpackage

// >>> verif/gms_net_model.sv
// Network side and serial request source facing the mode selector.
// Assumes the caller enters each task just after a rising hclk edge.
`timescale 1ns/10ps
module gms_net_model (
   input wire logic hclk,
   output logic eth_link_pulse,
   output logic eth_traffic,
   output logic eth_full_duplex,
   output logic eth_speed_100,
   output logic eth_mdi_crossed,
   output logic req_done,
   output logic [3:0] err_code,
   output logic err_strobe
);
   // Quiet start: no link, no pulses, code line holds a non-zero pattern
   initial begin
      {eth_link_pulse, eth_traffic, eth_full_duplex, eth_speed_100, eth_mdi_crossed} = 5'h00;
      req_done = 1'b0;
      err_strobe = 1'b0;
      err_code = 4'hA;
   end
   task automatic set_eth(input logic [4:0] v);
      {eth_link_pulse, eth_traffic, eth_full_duplex, eth_speed_100, eth_mdi_crossed} <= v;
      @(posedge hclk);
   endtask
   // one-cycle request pulses with a gap
   task automatic pulse_req(input int n);
      repeat (n) begin
         req_done <= 1'b1;
         @(posedge hclk);
         req_done <= 1'b0;
         @(posedge hclk);
      end
   endtask
   // Code is only valid with the strobe; afterwards it shows the inverse
   task automatic pulse_err(input logic [3:0] c);
      err_code <= c;
      err_strobe <= 1'b1;
      @(posedge hclk);
      err_strobe <= 1'b0;
      err_code <= ~c;
      @(posedge hclk);
   endtask
endmodule

// >>> verif/tb_gms_top.sv
// Self-checking bench of the mode selector: AHB master, resets and scenarios.
// Assumes the net model drives status levels, request and error strobes.
`timescale 1ns/10ps
`include "gms_cfg.svh"
module tb_gms_top;
   import gms_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [7:0] haddr = 8'h00, unit_id = 8'h2A, rtu_unit_out;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata, d;
   logic hreadyout, hresp, eth_mdix_sel, irq, lp, tr, fd, sp, xc, req_done, err_strobe;
   logic [3:0] baud_sw = 4'h0, line_sw = 4'h0, err_code;
   gms_link_t link_cfg;
   gms_led_t leds;
   int n_mismatch = 0, n_checks = 0, g, r, sr, rs;
   int bt[7] = '{2400, 4800, 9600, 19200, 38400, 57600, 115000};
   assign hready = hreadyout;
   // Clock of 50 ns
   initial forever #25 hclk = ~hclk;
   gms_top #(.WARN_CYC(200), .BLINK_CYC(4)) i_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .baud_select_switch(baud_sw), .line_parity_select_switch(line_sw),
      .rtu_unit_identifier(unit_id), .eth_link_pulse(lp), .eth_traffic(tr),
      .eth_full_duplex(fd), .eth_speed_100(sp), .eth_mdi_crossed(xc), .req_done(req_done),
      .err_code(err_code), .err_strobe(err_strobe), .link_cfg(link_cfg),
      .rtu_unit_out(rtu_unit_out), .eth_mdix_sel(eth_mdix_sel), .leds(leds), .irq(irq));
   gms_net_model i_net (.hclk(hclk), .eth_link_pulse(lp), .eth_traffic(tr),
      .eth_full_duplex(fd), .eth_speed_100(sp), .eth_mdi_crossed(xc),
      .req_done(req_done), .err_code(err_code), .err_strobe(err_strobe));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   // Bounded wait for hready at a rising edge
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         n_mismatch++;
         give_verdict();
      end
   endtask
   // One single word transfer; read data taken at the data phase edge
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      d = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic do_reset(input logic [3:0] b, input logic [3:0] l);
      hresetn <= 1'b0;
      baud_sw <= b;
      line_sw <= l;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
   endtask
   // Counts of lit cycles over one and a half blink periods
   task automatic sample();
      {g, r, sr, rs} = '0;
      repeat (12) begin
         @(posedge hclk);
         g += leds.eth_green;
         r += leds.eth_red;
         sr += leds.sys_red;
         rs += leds.rs_red;
      end
   endtask
   task automatic t_modes();
      logic [3:0] s;
      for (int i = 0; i < 3; i++) begin
         s = 4'hF - i[3:0];
         do_reset(s, s);
         ahb(`GMS_OFF_MODE, 1'b0, 32'h0);
         chk("mode", i + 1, d[9:8]);
         chk("valid", i < 2, link_cfg.valid);
         if (i < 2) begin
            chk("baud", 9600, link_cfg.baud);
            chk("par", 1, link_cfg.parity);
            chk("stop", 1, link_cfg.stop_bits);
            chk("line", 0, link_cfg.line);
            sample();
            chk("sys flash", sr > 0 && sr < 12, 1);
            if (i == 0) chk("rs flash", rs > 0 && rs < 12, 1);
         end
      end
      $display("test modes done");
   endtask
   task automatic t_baud();
      for (int i = 0; i < 8; i++) begin
         do_reset(i[3:0], 4'h3);
         chk("valid", i < 7, link_cfg.valid);
         if (i < 7) begin
            chk("baud", bt[i], link_cfg.baud);
            chk("bits", 8, link_cfg.data_bits);
            chk("stop", 1, link_cfg.stop_bits);
         end
      end
      $display("test baud done");
   endtask
   task automatic t_line();
      logic [3:0] l;
      for (int j = 0; j < 11; j++) begin
         l = (j == 9) ? 4'hF : j[3:0];
         unit_id <= 8'h20 + j[7:0];
         do_reset(4'h2, l);
         chk("valid", j != 10, link_cfg.valid);
         if (j < 10) begin
            chk("line", j == 9 ? 0 : j % 3, link_cfg.line);
            chk("par", j == 9 ? 0 : j / 3, link_cfg.parity);
         end
         if (j == 9) chk("unit", 8'h01, rtu_unit_out);
         else chk("unit pass", 8'h20 + j, rtu_unit_out);
      end
      $display("test line done");
   endtask
   task automatic t_hold();
      do_reset(4'h4, 4'h3);
      baud_sw <= 4'h0;
      line_sw <= 4'h5;
      repeat (5) @(posedge hclk);
      chk("baud", 38400, link_cfg.baud);
      ahb(`GMS_OFF_MODE, 1'b0, 32'h0);
      chk("mode reg", 32'h034, d);
      $display("test hold done");
   endtask
   task automatic t_eth();
      for (int m = 0; m < 4; m++) begin
         ahb(`GMS_OFF_ETH, 1'b1, m);
         // The LED follows the state register one cycle later
         @(posedge hclk);
         sample();
         if (m == 0 || m == 3) begin
            chk("eth g", m == 0 ? 12 : 0, g);
            chk("eth r", m == 3 ? 12 : 0, r);
         end else begin
            chk("eth g flash", 1, g > 0 && g < 12);
            chk("eth r", m == 2 ? 12 - g : 0, r);
         end
      end
      i_net.set_eth(5'h1B);
      repeat (2) @(posedge hclk);
      chk("ind", 3'h5, {leds.link_act, leds.full_dup, leds.fast});
      chk("mdix", 1, eth_mdix_sel);
      i_net.set_eth(5'h06);
      repeat (2) @(posedge hclk);
      chk("ind", 3'h3, {leds.link_act, leds.full_dup, leds.fast});
      chk("mdix", 0, eth_mdix_sel);
      i_net.set_eth(5'h08);
      repeat (2) @(posedge hclk);
      chk("ind", 3'h4, {leds.link_act, leds.full_dup, leds.fast});
      ahb(8'h3C, 1'b1, 32'hFFFF);
      ahb(8'h3C, 1'b0, 32'h0);
      chk("unmapped", 0, d);
      $display("test eth done");
   endtask
   task automatic t_req();
      do_reset(4'h2, 4'h0);
      ahb(`GMS_OFF_IRQ_MASK, 1'b1, 32'h7);
      i_net.pulse_req(5);
      @(posedge hclk);
      chk("cnt led", 5, leds.err);
      ahb(`GMS_OFF_REQ, 1'b0, 32'h0);
      chk("cnt reg", 5, d);
      i_net.pulse_req(11);
      @(posedge hclk);
      chk("wrap led", 0, leds.err);
      chk("irq", 1, irq);
      ahb(`GMS_OFF_IRQ_STAT, 1'b0, 32'h0);
      chk("stat", 32'h4, d);
      @(posedge hclk);
      chk("irq clr", 0, irq);
      $display("test req done");
   endtask
   task automatic t_err();
      i_net.pulse_err(4'h7);
      @(posedge hclk);
      chk("warn led", 7, leds.err);
      repeat (150) @(posedge hclk);
      chk("warn held", 7, leds.err);
      repeat (100) @(posedge hclk);
      chk("warn gone", 0, leds.err);
      i_net.pulse_err(4'h3);
      repeat (300) @(posedge hclk);
      chk("severe", 3, leds.err);
      i_net.pulse_err(4'h9);
      @(posedge hclk);
      chk("severe kept", 3, leds.err);
      ahb(`GMS_OFF_IRQ_STAT, 1'b0, 32'h0);
      chk("err stat", 32'h3, d);
      ahb(`GMS_OFF_ERR, 1'b1, 32'h1);
      ahb(`GMS_OFF_ERR, 1'b0, 32'h0);
      chk("err reg", 32'h33, d);
      sample();
      chk("sys red", 12, sr);
      chk("blank", 0, leds.err);
      $display("test err done");
   endtask
   // Watchdog against a hang
   initial begin
      #5000000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      do_reset(4'h2, 4'h0);
      t_modes();
      t_baud();
      t_line();
      t_hold();
      t_eth();
      t_req();
      t_err();
      give_verdict();
   end
endmodule
